// ---- rtl/sdg_pkg.sv ----
// Shared constants for the stepper driver serial datagram link
package sdg_pkg;
  // ==========================================================================
  // Datagram layout
  localparam int          FRAME_BITS    = 40;
  localparam int          DATA_BITS     = 32;
  localparam int          ADDR_BITS     = 7;
  localparam int          WRITE_BIT     = 39;
  localparam int          STAT_MSB      = 39;
  localparam int          STAT_LSB      = 32;
  localparam logic [6:0]  FRAME_EDGES   = 7'h50;
  // ==========================================================================
  // Reply status byte positions and source bits
  localparam int          STAT_STANDSTILL = 3;
  localparam int          STAT_STALL      = 2;
  localparam int          STAT_DRV_ERR    = 1;
  localparam int          STAT_RESET      = 0;
  localparam int          DRV_STANDSTILL_BIT = 31;
  localparam int          DRV_STALL_BIT      = 24;
  localparam logic [7:0]  STAT_RESET_VAL  = 8'h00;
  localparam logic [31:0] DATA_RESET_VAL  = 32'h0000_0000;
  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          SCK_PERIOD_NS = 800;
  localparam int          CS_GAP_NS     = 800;
  localparam logic [7:0]  SCK_HALF_CYC  = 8'(SCK_PERIOD_NS / 2 / CLK_PERIOD_NS);
  localparam logic [7:0]  CS_GAP_CYC    = 8'((CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ==========================================================================
  // Controller register map (byte addresses)
  localparam logic [7:0]  REG_TX_ADDR   = 8'h00;
  localparam logic [7:0]  REG_TX_DATA   = 8'h04;
  localparam logic [7:0]  REG_CTRL      = 8'h08;
  localparam logic [7:0]  REG_STATUS    = 8'h0C;
  localparam logic [7:0]  REG_RX_STAT   = 8'h10;
  localparam logic [7:0]  REG_RX_DATA   = 8'h14;
  localparam int          CTRL_START    = 0;
  localparam int          STATUS_BUSY   = 0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage

// ---- rtl/sdg_if.sv ----
// Four-wire serial link between controller and driver
`timescale 1ns/1ns
`default_nettype none
interface sdg_if;
  logic sck;
  logic select_low;
  logic mosi;
  logic miso;
  modport host
  (
    output sck,
    output select_low,
    output mosi,
    input  miso
  );
  modport dev
  (
    input  sck,
    input  select_low,
    input  mosi,
    output miso
  );
endinterface
`default_nettype wire

// ---- rtl/sdg_device.sv ----
// Driver end of the serial datagram link
//
// Notes on behaviour
// - Every transaction is one 40-bit datagram
// - Master holds select low through datagram
// - Address byte then four data bytes
// - Always transfer full 32 data bits
// - Bit 39 set means write
// - Reply shifted out on every datagram
// - After read, reply holds read register
// - After write, reply echoes written data
// - Read datagram stores nothing
// - Top reply byte is status byte
// - Status captured at datagram end
// - Status bit 3 is standstill flag
// - Status bit 2 is stall flag
// - Status bit 1 mirrors driver error
// - Status bit 0 mirrors reset flag
// - Register values right aligned, unmodified
// - MSB first, sample rise, drive fall
// - Extra bits emerge after 40 clocks
// - Select rise executes last 40 bits
// - Master keeps clock at one eighth rate
`timescale 1ns/1ns
`default_nettype none
module sdg_device
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  sdg_if.dev               link,
  output logic [6:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  output logic             reg_we,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata,
  input  wire logic [31:0] drv_status,
  input  wire logic        driver_error,
  input  wire logic        reset_flag
);
  // ==========================================================================
  // Pin synchronisers
  logic [1:0] sck_sync;
  logic [1:0] cs_sync;
  logic [1:0] sdi_sync;
  logic       sck_s;
  logic       cs_s;
  logic       sdi_s;
  logic [1:0] next_sck_sync;
  logic [1:0] next_cs_sync;
  logic [1:0] next_sdi_sync;

  // Pins come from the link clock, so each passes two flops before any logic reads it
  always_comb
  begin
    next_sck_sync = {sck_sync[0], link.sck};
    next_cs_sync  = {cs_sync[0], link.select_low};
    next_sdi_sync = {sdi_sync[0], link.mosi};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_sync <= 2'h3;
      cs_sync  <= 2'h3;
      sdi_sync <= 2'h0;
    end
    else
    begin
      sck_sync <= next_sck_sync;
      cs_sync  <= next_cs_sync;
      sdi_sync <= next_sdi_sync;
    end
  end

  assign sck_s = sck_sync[1];
  assign cs_s  = cs_sync[1];
  assign sdi_s = sdi_sync[1];

  // ==========================================================================
  // Frame state
  logic                           sck_d;
  logic                           cs_d;
  logic [sdg_pkg::FRAME_BITS-1:0] shift_reg;
  logic                           sdo_q;
  logic [sdg_pkg::DATA_BITS-1:0]  reply_data;
  logic [7:0]                     status_q;
  logic                           next_sck_d;
  logic                           next_cs_d;
  logic [sdg_pkg::FRAME_BITS-1:0] next_shift_reg;
  logic                           next_sdo_q;
  logic [sdg_pkg::DATA_BITS-1:0]  next_reply_data;
  logic [7:0]                     next_status_q;
  logic [6:0]                     next_reg_addr;
  logic [31:0]                    next_reg_wdata;
  logic                           next_reg_we;
  logic                           next_reg_rd;
  logic                           cs_fall;
  logic                           cs_rise;
  logic                           sck_rise;
  logic                           sck_fall;

  assign cs_fall  = cs_d & ~cs_s;
  assign cs_rise  = ~cs_d & cs_s;
  assign sck_rise = ~sck_d & sck_s & ~cs_s;
  assign sck_fall = sck_d & ~sck_s & ~cs_s;

  always_comb
  begin
    next_sck_d      = sck_s;
    next_cs_d       = cs_s;
    next_shift_reg  = shift_reg;
    next_sdo_q      = sdo_q;
    // Whole reply is loaded at frame start so bit 39 is on the pin before the first rise
    if (cs_fall)
    begin
      next_shift_reg = {status_q, reply_data};
      next_sdo_q     = status_q[7];
    end
    else if (sck_fall)
    begin
      next_sdo_q = shift_reg[sdg_pkg::FRAME_BITS-1];
    end
    // One register serves both directions, so surplus input bits reappear 40 clocks later
    if (sck_rise)
    begin
      next_shift_reg = {shift_reg[sdg_pkg::FRAME_BITS-2:0], sdi_s};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_d     <= 1'b1;
      cs_d      <= 1'b1;
      shift_reg <= {sdg_pkg::FRAME_BITS{1'b0}};
      sdo_q     <= 1'b0;
    end
    else
    begin
      sck_d     <= next_sck_d;
      cs_d      <= next_cs_d;
      shift_reg <= next_shift_reg;
      sdo_q     <= next_sdo_q;
    end
  end

  // ==========================================================================
  // Command execution and reply capture
  always_comb
  begin
    next_reply_data = reply_data;
    next_status_q   = status_q;
    next_reg_addr   = reg_addr;
    next_reg_wdata  = reg_wdata;
    next_reg_we     = 1'b0;
    next_reg_rd     = 1'b0;
    if (cs_rise)
    begin
      // Only the last 40 bits shifted in remain in the register
      next_reg_addr = shift_reg[sdg_pkg::STAT_LSB+sdg_pkg::ADDR_BITS-1:sdg_pkg::STAT_LSB];
      next_status_q = {4'h0,
                       drv_status[sdg_pkg::DRV_STANDSTILL_BIT],
                       drv_status[sdg_pkg::DRV_STALL_BIT],
                       driver_error,
                       reset_flag};
      if (shift_reg[sdg_pkg::WRITE_BIT])
      begin
        next_reg_we     = 1'b1;
        next_reg_wdata  = shift_reg[sdg_pkg::DATA_BITS-1:0];
        next_reply_data = shift_reg[sdg_pkg::DATA_BITS-1:0];
      end
      else
      begin
        next_reg_rd = 1'b1;
      end
    end
    // Read data is taken one cycle after the address is presented; clear-on-read
    // flags were already sampled into the status byte in the cycle before
    if (reg_rd)
    begin
      next_reply_data = reg_rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reply_data <= sdg_pkg::DATA_RESET_VAL;
      status_q   <= sdg_pkg::STAT_RESET_VAL;
      reg_addr   <= 7'h00;
      reg_wdata  <= 32'h0000_0000;
      reg_we     <= 1'b0;
      reg_rd     <= 1'b0;
    end
    else
    begin
      reply_data <= next_reply_data;
      status_q   <= next_status_q;
      reg_addr   <= next_reg_addr;
      reg_wdata  <= next_reg_wdata;
      reg_we     <= next_reg_we;
      reg_rd     <= next_reg_rd;
    end
  end

  assign link.miso = sdo_q;
endmodule
`default_nettype wire

// ---- rtl/sdg_host.sv ----
// Controller end of the serial datagram link with an AHB-Lite register slave
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sdg_host
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  sdg_if.host              link
);
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_RUN  = 2'b10,
    ST_GAP  = 2'b11
  } sdg_state_t;

  // ==========================================================================
  // Reply pin synchroniser
  logic [1:0] miso_sync;
  logic       miso_s;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      miso_sync <= 2'h0;
    else
      miso_sync <= {miso_sync[0], link.miso};
  end

  assign miso_s = miso_sync[1];

  // ==========================================================================
  // Bus slave and frame engine
  sdg_state_t  state,     next_state;
  logic [7:0]  cnt,       next_cnt;
  logic [6:0]  edge_cnt,  next_edge_cnt;
  logic [39:0] tx_sh,     next_tx_sh;
  logic [39:0] rx_sh,     next_rx_sh;
  logic        sck_q,     next_sck_q;
  logic        cs_q,      next_cs_q;
  logic        mosi_q,    next_mosi_q;
  logic [7:0]  tx_addr,   next_tx_addr;
  logic [31:0] tx_data,   next_tx_data;
  logic [7:0]  rx_stat,   next_rx_stat;
  logic [31:0] rx_data,   next_rx_data;
  logic        wr_pend,   next_wr_pend;
  logic [7:0]  wr_addr,   next_wr_addr;
  logic [31:0] next_hrdata;
  logic        start;
  logic        accept;
  logic        unused_ok;

  assign accept    = hsel & hready & (htrans == sdg_pkg::HTRANS_NONSEQ);
  assign unused_ok = &{1'b0, hsize, haddr[31:8]};

  always_comb
  begin
    next_wr_pend = accept & hwrite;
    next_wr_addr = accept ? haddr[7:0] : wr_addr;
    next_hrdata  = hrdata;
    next_tx_addr = tx_addr;
    next_tx_data = tx_data;
    start        = 1'b0;
    // Read data is latched in the address phase, so every access ends with no wait state
    if (accept && !hwrite)
    begin
      case (haddr[7:0])
        sdg_pkg::REG_TX_ADDR: next_hrdata = {24'h00_0000, tx_addr};
        sdg_pkg::REG_TX_DATA: next_hrdata = tx_data;
        sdg_pkg::REG_STATUS:  next_hrdata = {31'h0000_0000, state != ST_IDLE};
        sdg_pkg::REG_RX_STAT: next_hrdata = {24'h00_0000, rx_stat};
        sdg_pkg::REG_RX_DATA: next_hrdata = rx_data;
        default:              next_hrdata = 32'h0000_0000;
      endcase
    end
    if (wr_pend)
    begin
      case (wr_addr)
        sdg_pkg::REG_TX_ADDR: next_tx_addr = hwdata[7:0];
        sdg_pkg::REG_TX_DATA: next_tx_data = hwdata;
        sdg_pkg::REG_CTRL:    start        = hwdata[sdg_pkg::CTRL_START];
        default:              start        = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_edge_cnt = edge_cnt;
    next_tx_sh    = tx_sh;
    next_rx_sh    = rx_sh;
    next_sck_q    = sck_q;
    next_cs_q     = cs_q;
    next_mosi_q   = mosi_q;
    next_rx_stat  = rx_stat;
    next_rx_data  = rx_data;
    case (state)
      ST_IDLE:
      begin
        next_sck_q = 1'b1;
        // A start while a frame runs is dropped; software polls busy first
        if (start)
        begin
          next_tx_sh = {tx_addr, tx_data};
          next_cs_q  = 1'b0;
          next_cnt   = 8'h00;
          next_state = ST_LEAD;
        end
      end
      ST_LEAD:
      begin
        next_cnt = cnt + 8'h01;
        if (cnt == sdg_pkg::SCK_HALF_CYC - 8'h01)
        begin
          next_cnt      = 8'h00;
          next_edge_cnt = 7'h00;
          next_state    = ST_RUN;
        end
      end
      ST_RUN:
      begin
        next_cnt = cnt + 8'h01;
        if (cnt == sdg_pkg::SCK_HALF_CYC - 8'h01)
        begin
          next_cnt      = 8'h00;
          next_edge_cnt = edge_cnt + 7'h01;
          if (edge_cnt == sdg_pkg::FRAME_EDGES)
          begin
            // Last reply bit taken a half period after the final rise, then select released
            next_rx_sh                  = {rx_sh[38:0], miso_s};
            {next_rx_stat, next_rx_data} = {rx_sh[38:0], miso_s};
            next_cs_q                   = 1'b1;
            next_state                  = ST_GAP;
          end
          else if (!edge_cnt[0])
          begin
            // Reply bits are taken late, at the next fall, to cover both synchroniser delays
            next_sck_q  = 1'b0;
            next_mosi_q = tx_sh[39];
            next_tx_sh  = {tx_sh[38:0], 1'b0};
            if (edge_cnt != 7'h00)
              next_rx_sh = {rx_sh[38:0], miso_s};
          end
          else
          begin
            next_sck_q = 1'b1;
          end
        end
      end
      ST_GAP:
      begin
        next_cnt = cnt + 8'h01;
        if (cnt == sdg_pkg::CS_GAP_CYC - 8'h01)
        begin
          next_cnt   = 8'h00;
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_cs_q  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state     <= ST_IDLE;
      cnt       <= 8'h00;
      edge_cnt  <= 7'h00;
      tx_sh     <= 40'h00_0000_0000;
      rx_sh     <= 40'h00_0000_0000;
      sck_q     <= 1'b1;
      cs_q      <= 1'b1;
      mosi_q    <= 1'b0;
      tx_addr   <= 8'h00;
      tx_data   <= 32'h0000_0000;
      rx_stat   <= 8'h00;
      rx_data   <= 32'h0000_0000;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      edge_cnt  <= next_edge_cnt;
      tx_sh     <= next_tx_sh;
      rx_sh     <= next_rx_sh;
      sck_q     <= next_sck_q;
      cs_q      <= next_cs_q;
      mosi_q    <= next_mosi_q;
      tx_addr   <= next_tx_addr;
      tx_data   <= next_tx_data;
      rx_stat   <= next_rx_stat;
      rx_data   <= next_rx_data;
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= unused_ok;
    end
  end

  assign link.sck        = sck_q;
  assign link.select_low = cs_q;
  assign link.mosi       = mosi_q;
endmodule
`default_nettype wire

// ---- tb/sdg_link_asserts.sv ----
// Checker for the serial link between controller and driver ends
`timescale 1ns/1ns
`default_nettype none
module sdg_link_asserts
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sck,
  input wire logic select_low,
  input wire logic mosi,
  input wire logic miso
);
  // ==========================================================================
  // Helper logic: falls of the serial clock within a frame
  logic [5:0] fall_cnt;
  logic [5:0] next_fall_cnt;
  logic       sck_q;

  always_comb
  begin
    next_fall_cnt = fall_cnt;
    if (select_low)
      next_fall_cnt = 6'h00;
    else if (sck_q && !sck)
      next_fall_cnt = fall_cnt + 6'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fall_cnt <= 6'h00;
      sck_q    <= 1'b1;
    end
    else
    begin
      fall_cnt <= next_fall_cnt;
      sck_q    <= sck;
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_idle_high;
    select_low |-> sck;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("clock not high outside frame");

  property p_lead;
    $fell(select_low) |-> sck [*8] ##1 !sck;
  endproperty
  a_lead: assert property (p_lead) else $error("bad lead after select");

  property p_sck_low;
    $fell(sck) |-> (!sck) [*4] ##1 sck;
  endproperty
  a_sck_low: assert property (p_sck_low) else $error("clock low phase length");

  property p_mosi_hold;
    !select_low && $rose(sck) |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("data out moved at rise");

  // First fall is skipped: the reply's top bit may be launched at that edge
  property p_miso_hold;
    !select_low && $fell(sck) && fall_cnt != 6'h00 |-> $stable(miso);
  endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("reply moved at fall");

  property p_stat_zero;
    !select_low && $fell(sck) && fall_cnt >= 6'h01 && fall_cnt <= 6'h04 |-> !miso;
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("unused status bit set");

  property p_frame_len;
    $rose(select_low) |-> fall_cnt == 6'(sdg_pkg::FRAME_BITS);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame clock count");

  property p_gap;
    $rose(select_low) |-> select_low [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("select gap too short");
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Testbench: controller and driver ends joined, register file model on the driver side
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic [6:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_we;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] drv_status = 32'h8100_0000;
  logic        driver_error = 1'b1;
  logic        reset_flag = 1'b1;
  logic [31:0] regs [16] = '{default: 32'h0000_0000};
  int          err_total = 0;
  int          check_count = 0;
  // ==========================================================================
  // Frame table: address byte, data, drive status, expected reply
  logic [7:0]  t_a [7] = '{8'h85, 8'h05, 8'h01, 8'h7F, 8'h85, 8'h05, 8'h05};
  logic [31:0] t_d [7] = '{32'h00AB_CDEF, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000,
                           32'h1234_5678, 32'hFFFF_FFFF, 32'h0000_0000};
  logic [31:0] t_v [7] = '{32'h8100_0000, 32'h8100_0000, 32'h0100_0000, 32'h8000_0000,
                           32'h8000_0000, 32'h8000_0000, 32'h8000_0000};
  logic [7:0]  t_s [7] = '{8'h00, 8'h0F, 8'h0F, 8'h07, 8'h08, 8'h08, 8'h08};
  logic [31:0] t_r [7] = '{32'h0000_0000, 32'h00AB_CDEF, 32'h00AB_CDEF, 32'h0000_0003,
                           32'h0000_0000, 32'h1234_5678, 32'h1234_5678};

  always #50 hclk = ~hclk;

  sdg_if link_if ();

  sdg_host u_sdg_host
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hready),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .link      (link_if.host)
  );

  sdg_device u_sdg_device
  (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .link         (link_if.dev),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_we       (reg_we),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .drv_status   (drv_status),
    .driver_error (driver_error),
    .reset_flag   (reset_flag)
  );

  sdg_link_asserts u_sdg_link_asserts
  (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .sck        (link_if.sck),
    .select_low (link_if.select_low),
    .mosi       (link_if.mosi),
    .miso       (link_if.miso)
  );

  // ==========================================================================
  // Register file model; only 16 words, all else reads zero
  assign reg_rdata = (reg_addr == 7'h01) ? {30'h0000_0000, driver_error, reset_flag} :
                     (reg_addr < 7'h10) ? regs[reg_addr[3:0]] : 32'h0000_0000;

  always @(posedge hclk)
  begin
    if (reg_we && reg_addr < 7'h10)
      regs[reg_addr[3:0]] <= reg_wdata;
    if (reg_rd && reg_addr == 7'h01)
    begin
      driver_error <= 1'b0;
      reset_flag   <= 1'b0;
    end
  end

  // ==========================================================================
  // Tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= sdg_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    cmp({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  task automatic frame(input logic [7:0] a, input logic [31:0] d, input logic [7:0] es, input logic [31:0] ed);
    logic [31:0] q;
    bus(1'b1, sdg_pkg::REG_TX_ADDR, {24'h00_0000, a}, q);
    bus(1'b1, sdg_pkg::REG_TX_DATA, d, q);
    bus(1'b1, sdg_pkg::REG_CTRL, 32'h0000_0001, q);
    q = 32'h0000_0001;
    // Busy is polled, not timed: the watchdog bounds a hung frame
    while (q[sdg_pkg::STATUS_BUSY] !== 1'b0) bus(1'b0, sdg_pkg::REG_STATUS, 32'h0000_0000, q);
    bus(1'b0, sdg_pkg::REG_RX_STAT, 32'h0000_0000, q);
    cmp(q, {24'h00_0000, es});
    bus(1'b0, sdg_pkg::REG_RX_DATA, 32'h0000_0000, q);
    cmp(q, ed);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================================
  // Sequence
  initial
  begin
    logic [31:0] q;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, sdg_pkg::REG_TX_DATA, 32'hCAFE_5A5A, q);
    bus(1'b0, sdg_pkg::REG_TX_DATA, 32'h0000_0000, q);
    cmp(q, 32'hCAFE_5A5A);
    bus(1'b0, 8'h18, 32'h0000_0000, q);
    cmp(q, 32'h0000_0000);
    $display("register bus test done");
    for (int i = 0; i < 7; i++)
    begin
      drv_status <= t_v[i];
      frame(t_a[i], t_d[i], t_s[i], t_r[i]);
      $display("frame test %0d done", i);
    end
    cmp(regs[5], 32'h1234_5678);
    finish_test;
  end

  initial
  begin
    #(4_000_000);
    err_total++;
    finish_test;
  end
endmodule
`default_nettype wire
